// >>> core/dbs_pkg.sv
package dbs_pkg;

	// ============================================================
	// Base address decode
	localparam logic [19:0] DBS_BASE_FIRST  = 20'h40000;
	localparam logic [19:0] DBS_BASE_SECOND = 20'h80000;
	localparam int          DBS_REGION_HI   = 19;
	localparam int          DBS_REGION_LO   = 18;
	localparam int          DBS_PAGE_BIT    = 17;

	// ============================================================
	// Sequencer
	localparam int          DBS_SEQ_W       = 3;
	localparam logic [2:0]  DBS_SEQ_LAST    = 3'h7;
	localparam int          DBS_ROM_W       = 8;

	// Lookup word field positions
	localparam int          DBS_F_ROW       = 0;
	localparam int          DBS_F_COL       = 1;
	localparam int          DBS_F_CAP1      = 2;
	localparam int          DBS_F_CAP2      = 3;
	localparam int          DBS_F_ABZ       = 4;
	localparam int          DBS_F_HIGH      = 5;
	localparam int          DBS_F_DSEL      = 6;
	localparam int          DBS_F_ASEL      = 7;

	// Control word reset value: strobes idle
	localparam logic [7:0]  DBS_CTRL_RESET  = 8'h00;

	// 8 states x 8 bits = 64-bit table; step 0-3 low byte, 4-6 high byte, 7 idle
	localparam logic [63:0] DBS_ROM = {
		8'h00, // 7 idle, chip refreshes itself
		8'h28, // 6 high half, no column, capture high
		8'h63, // 5 high column, page high
		8'h71, // 4 high row, page high
		8'h00, // 3 precharge
		8'h06, // 2 low column, capture low
		8'h03, // 1 low column
		8'h81  // 0 low row
	};

endpackage : dbs_pkg

// >>> core/dbs_sequencer.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Board answers at one of two strap-chosen base addresses.
// - Strap and decoded address bits gate into one board select.
// - Writes pass the host word one byte per step by data-byte select.
// - Read bytes captured in upper and lower holding registers by own strobes.
// - Sixteen address bits go out eight at a time by half select.
// - Page select is data-byte select XOR host address bit 17.
// - Valid cycle clears the three-bit counter while address latch strobe high.
// - Counter advances each clock through states 0 to 7.
// - Counting qualified by latch strobe and address bits 18 and 19.
// - Each state indexes a fixed 64-bit control table.
// - Table outputs registered before driving strobes and selects.
// - Captured bytes reach host bus only during memory read command.
// - Eight one-bit chips with internal refresh; no refresh addresses.
module dbs_sequencer
	import dbs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        base_select_strap,
	input  wire logic        address_latch_enable,
	input  wire logic        byte_high_enable,
	input  wire logic        memory_read_command,
	input  wire logic [19:1] host_address,
	input  wire logic [15:0] host_data_in,
	output logic      [15:0] host_data_out,
	output logic             host_data_oe,
	output logic      [7:0]  mem_address,
	output logic      [7:0]  mem_data_out,
	input  wire logic [7:0]  mem_data_in,
	output logic             mem_page_high,
	output logic             row_strobe,
	output logic             column_strobe,
	output logic             address_bit_zero,
	output logic             byte_high_strobe,
	output logic             board_select
);

	// ============================================================
	// Input synchronisers
	// Byte enable pin unused: the table fixes the byte order itself
	logic [1:0]  ale_sync;
	logic [1:0]  rd_sync;
	logic [1:0]  strap_sync;
	logic        ale;
	logic        rd;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			ale_sync   <= 2'h0;
			rd_sync    <= 2'h0;
			strap_sync <= 2'h0;
		end
		else
		begin
			ale_sync   <= {ale_sync[0], address_latch_enable};
			rd_sync    <= {rd_sync[0], memory_read_command};
			strap_sync <= {strap_sync[0], base_select_strap};
		end
	end

	assign ale = ale_sync[1];
	assign rd  = rd_sync[1];

	// ============================================================
	// Board select: strap high picks first base (single board)
	logic [1:0] region;
	logic [1:0] wanted;
	logic       hit;
	logic       cycle_on;
	logic [2:0] address_count;

	assign region = host_address[DBS_REGION_HI:DBS_REGION_LO];
	assign wanted = strap_sync[1] ? DBS_BASE_FIRST[DBS_REGION_HI:DBS_REGION_LO]
	                              : DBS_BASE_SECOND[DBS_REGION_HI:DBS_REGION_LO];
	assign hit    = (region == wanted);

	// Host holds address through the cycle, so select is held from ALE
	always_ff @(posedge clock)
	begin
		if (rst)
			cycle_on <= 1'b0;
		else if (ale)
			cycle_on <= hit;
		else if (board_select && address_count == DBS_SEQ_LAST)
			cycle_on <= 1'b0;
	end

	assign board_select = cycle_on && hit;

	// ============================================================
	// Sequence counter
	// Parks at the last state until the next latch strobe that hits this board's base

	always_ff @(posedge clock)
	begin
		if (rst)
			address_count <= 3'h0;
		else if (ale && hit)
			address_count <= 3'h0;
		else if (board_select && address_count != DBS_SEQ_LAST)
			address_count <= address_count + 3'h1;
	end

	// ============================================================
	// Lookup table and output register
	logic [7:0] next_ctrl;
	logic [7:0] ctrl;

	always_comb
	begin
		next_ctrl = DBS_ROM[address_count*DBS_ROM_W +: DBS_ROM_W];
		if (!board_select)
			next_ctrl = DBS_CTRL_RESET;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			ctrl <= DBS_CTRL_RESET;
		else
			ctrl <= next_ctrl;
	end

	assign row_strobe       = ctrl[DBS_F_ROW];
	assign column_strobe    = ctrl[DBS_F_COL];
	assign address_bit_zero = ctrl[DBS_F_ABZ];
	assign byte_high_strobe = ctrl[DBS_F_HIGH];

	logic data_byte_select;
	logic address_half_select;
	assign data_byte_select    = ctrl[DBS_F_DSEL];
	assign address_half_select = ctrl[DBS_F_ASEL];

	// ============================================================
	// Memory address, page and write data paths
	// No refresh address: chips refresh themselves on row cycles
	// Selects act a clock after their table word, so addresses trail the strobes
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mem_address   <= 8'h00;
			mem_page_high <= 1'b0;
			mem_data_out  <= 8'h00;
		end
		else
		begin
			mem_address   <= address_half_select ? host_address[8:1] : host_address[16:9];
			mem_page_high <= data_byte_select ^ host_address[DBS_PAGE_BIT];
			mem_data_out  <= data_byte_select ? host_data_in[15:8] : host_data_in[7:0];
		end
	end

	// ============================================================
	// Read capture and host drive
	// Captures also run on writes; harmless, the bus is driven on reads only
	always_ff @(posedge clock)
	begin
		if (rst)
			host_data_out <= 16'h0000;
		else
		begin
			if (ctrl[DBS_F_CAP1])
				host_data_out[7:0] <= mem_data_in;
			if (ctrl[DBS_F_CAP2])
				host_data_out[15:8] <= mem_data_in;
		end
	end

	assign host_data_oe = rd && cycle_on;

	// ============================================================
	// Checks
	a_count_clear: assert property (@(posedge clock) disable iff (rst)
		(ale && hit) |=> address_count == 3'h0) else $error("counter not cleared");
	a_count_step: assert property (@(posedge clock) disable iff (rst)
		(!ale && board_select && address_count != 3'h7) |=> address_count == $past(address_count) + 3'h1)
		else $error("counter did not step");
	a_count_hold: assert property (@(posedge clock) disable iff (rst)
		(!ale && !board_select) |=> $stable(address_count)) else $error("counter ran unselected");
	a_cycle_end: assert property (@(posedge clock) disable iff (rst)
		(!ale && board_select && address_count == DBS_SEQ_LAST) |=> !board_select)
		else $error("cycle did not end");
	a_idle_strobes: assert property (@(posedge clock) disable iff (rst)
		!board_select |=> !row_strobe && !column_strobe) else $error("strobe while idle");
	a_idle_captures: assert property (@(posedge clock) disable iff (rst)
		!board_select |=> !ctrl[DBS_F_CAP1] && !ctrl[DBS_F_CAP2]) else $error("capture while idle");
	a_table_reg: assert property (@(posedge clock) disable iff (rst)
		board_select |=> ctrl == DBS_ROM[$past(address_count)*8 +: 8]) else $error("table word wrong");
	a_page_xor: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> mem_page_high == ($past(data_byte_select) ^ $past(host_address[17]))) else $error("page wrong");
	a_data_drive: assert property (@(posedge clock) disable iff (rst)
		host_data_oe |-> rd && board_select) else $error("bus driven without selected read");
	a_addr_mux: assert property (@(posedge clock) disable iff (rst)
		address_half_select |=> mem_address == $past(host_address[8:1])) else $error("address half wrong");
	a_wr_byte: assert property (@(posedge clock) disable iff (rst)
		data_byte_select |=> mem_data_out == $past(host_data_in[15:8])) else $error("write byte wrong");
	a_cap_low: assert property (@(posedge clock) disable iff (rst)
		ctrl[DBS_F_CAP1] |=> host_data_out[7:0] == $past(mem_data_in)) else $error("low capture wrong");
	a_cap_high: assert property (@(posedge clock) disable iff (rst)
		ctrl[DBS_F_CAP2] |=> host_data_out[15:8] == $past(mem_data_in)) else $error("high capture wrong");
	a_sel_base: assert property (@(posedge clock) disable iff (rst)
		board_select |-> {host_address[DBS_REGION_HI:DBS_REGION_LO], 18'h00000} ==
		                 (strap_sync[1] ? DBS_BASE_FIRST : DBS_BASE_SECOND))
		else $error("select outside base");
	a_abz_high: assert property (@(posedge clock) disable iff (rst)
		address_bit_zero |-> byte_high_strobe) else $error("address bit zero outside high half");

	c_full_run: cover property (@(posedge clock) board_select && address_count == 3'h7);
	c_read: cover property (@(posedge clock) host_data_oe);
	c_second_base: cover property (@(posedge clock) board_select && !strap_sync[1]);
	c_write_high: cover property (@(posedge clock) board_select && !rd && data_byte_select);
	c_restart: cover property (@(posedge clock) ale && hit && cycle_on);

endmodule // dbs_sequencer

`default_nettype wire

// >>> verification/dbs_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Host side: latch strobe first, command dropped two clocks before cycle end
module dbs_host_model
(
	input  wire logic        clock,
	input  wire logic        start,
	input  wire logic [19:1] cyc_addr,
	input  wire logic        cyc_read,
	output logic             address_latch_enable,
	output logic             memory_read_command,
	output logic      [19:1] host_address,
	output logic             busy
);
	int   step;
	logic rd;
	initial
	begin
		busy = 1'b0;
		address_latch_enable = 1'b0;
		memory_read_command = 1'b0;
		host_address = '0;
	end
	always @(posedge clock)
	begin
		if (start && !busy)
		begin
			busy <= 1'b1;
			step <= 0;
			rd <= cyc_read;
			host_address <= cyc_addr;
			address_latch_enable <= 1'b1;
		end
		else if (busy)
		begin
			step <= step + 1;
			address_latch_enable <= step < 4;
			memory_read_command <= rd && step < 28;
			if (step == 30)
			begin
				busy <= 1'b0;
				// Released lines must not keep a stale address
				host_address <= ~host_address;
			end
		end
	end
endmodule // dbs_host_model
`default_nettype wire

// >>> verification/dbs_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dbs_sequencer_tb;
	logic        clock = 0, rst = 1, strap = 1, start = 0, rd = 0, busy, ale, rd_cmd, oe, bsel;
	logic        row, col, a0, bhs, page, lo_pg, hi_pg;
	logic [19:1] addr = '0, haddr;
	logic [15:0] wdata = 16'h0000, rdata;
	logic [7:0]  maddr, mdout, mdin = 8'h00, lo_d, hi_d, lo_a;
	int          mismatches = 0, samples_checked = 0, cnt[6];
	initial forever #20 clock = ~clock;
	dbs_host_model i_host(.clock(clock), .start(start), .cyc_addr(addr), .cyc_read(rd),
		.address_latch_enable(ale), .memory_read_command(rd_cmd), .host_address(haddr), .busy(busy));
	dbs_sequencer i_dut(.clock(clock), .rst(rst), .base_select_strap(strap), .address_latch_enable(ale),
		.byte_high_enable(1'b1), .memory_read_command(rd_cmd), .host_address(haddr), .host_data_in(wdata),
		.host_data_out(rdata), .host_data_oe(oe), .mem_address(maddr), .mem_data_out(mdout),
		.mem_data_in(mdin), .mem_page_high(page), .row_strobe(row), .column_strobe(col),
		.address_bit_zero(a0), .byte_high_strobe(bhs), .board_select(bsel));
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		samples_checked++;
		if (exp !== got)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ============================================================
	// One host cycle, strobes counted and mid-cycle values sampled
	task automatic run_cycle(logic [19:1] a, logic r, logic sel);
		int   t;
		logic row_q;
		@(posedge clock) #2;
		addr = a;
		rd = r;
		start = 1'b1;
		// Writes and reads fetch different bytes so a stale capture shows
		mdin = r ? 8'h3c : 8'h96;
		cnt = '{default:0};
		row_q = 1'b0;
		@(posedge clock) #2;
		start = 1'b0;
		for (t = 0; t < 40 && (busy || t < 2); t++)
		begin
			@(posedge clock) #2;
			// Row strobe counted in pulses: the first one stretches over the latch strobe
			cnt[0] += int'(row === 1'b1 && row_q !== 1'b1);
			row_q = row;
			cnt[1] += col;
			cnt[2] += a0;
			cnt[3] += bhs;
			cnt[4] += oe;
			cnt[5] += bsel;
			// Memory returns the high byte once the high half begins
			if (bhs === 1'b1)
				mdin = r ? 8'hc3 : 8'h69;
			if (col === 1'b1 && bhs === 1'b0) {lo_d, lo_a, lo_pg} = {mdout, maddr, page};
			if (col === 1'b1 && bhs === 1'b1) {hi_d, hi_pg} = {mdout, page};
		end
		if (busy)
		begin
			mismatches++;
			end_sim();
		end
		check("row pulses", sel ? 16'h0002 : 16'h0000, 16'(cnt[0]));
		check("column count", sel ? 16'h0003 : 16'h0000, 16'(cnt[1]));
		check("addr bit zero", sel ? 16'h0001 : 16'h0000, 16'(cnt[2]));
		check("high strobe", sel ? 16'h0003 : 16'h0000, 16'(cnt[3]));
		check("select seen", 16'(sel), 16'(cnt[5] > 0));
		check("drive seen", 16'(sel && r), 16'(cnt[4] > 0));
		if (sel && !r) check("write bytes", wdata, {hi_d, lo_d});
		if (sel && !r) check("column addr", 16'(a[16:9]), 16'(lo_a));
		if (sel) check("page", {14'h0, ~a[17], a[17]}, {14'h0, hi_pg, lo_pg});
		if (sel && r) check("read word", 16'hc33c, rdata);
	endtask
	task automatic base_strap();
		run_cycle(19'h25678, 1'b0, 1'b1);
		run_cycle(19'h45678, 1'b1, 1'b0);
		strap = 1'b0;
		repeat (4) @(posedge clock);
		run_cycle(19'h45678, 1'b1, 1'b1);
		run_cycle(19'h25678, 1'b0, 1'b0);
		strap = 1'b1;
		repeat (4) @(posedge clock);
	endtask
	task automatic page_write();
		wdata = 16'ha55a;
		run_cycle(19'h35a01, 1'b0, 1'b1);
	endtask
	task automatic back_to_back();
		run_cycle(19'h300ff, 1'b1, 1'b1);
		wdata = 16'h1e2d;
		run_cycle(19'h2ff00, 1'b0, 1'b1);
	endtask
	initial
	begin
		repeat (12) @(posedge clock);
		#2 rst = 1'b0;
		repeat (3) @(posedge clock);
		base_strap();
		page_write();
		back_to_back();
		end_sim();
	end
endmodule // dbs_sequencer_tb
`default_nettype wire
